//--- ssrc_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host side of the serial port
// ****************************************
module ssrc_host_model (
  // Serial pins
  output logic spi_clk,
  output logic spi_data,
  output logic spi_le
);
  initial begin
    spi_clk  = 1'b0;
    spi_data = 1'b0;
    spi_le   = 1'b0;
  end

  // Clock runs only inside a frame, MSB first
  // Data is inverted once the frame ends so a stale bit never looks valid
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      spi_data = w[i];
      #3 spi_clk = 1'b1;
      #3 spi_clk = 1'b0;
    end
    spi_data = ~w[0];
    #3 spi_le = 1'b1;
    #40 spi_le = 1'b0;
    #40;
  endtask
endmodule // ssrc_host_model

//--- ssrc_pkg.sv
package ssrc_pkg;

  // ****************************************
  // Serial word layout
  // ****************************************
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned NUM_REGS    = 8;
  localparam int unsigned SEL_W       = 3;
  localparam int unsigned SEL_LSB     = 0;

  // Register select codes
  localparam logic [2:0] SEL_INT_DIV  = 3'h0;
  localparam logic [2:0] SEL_MOD_DIV  = 3'h1;
  localparam logic [2:0] SEL_FRAC_DIV = 3'h2;
  localparam logic [2:0] SEL_BIAS     = 3'h5;
  localparam logic [2:0] SEL_LDO      = 3'h6;
  localparam logic [2:0] SEL_MONITOR  = 3'h7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned INT_RATIO_LSB  = 3;
  localparam int unsigned INT_RATIO_W    = 7;
  localparam int unsigned DIV_MODE_BIT   = 10;
  localparam int unsigned MOD_LSB        = 3;
  localparam int unsigned MOD_W          = 11;
  localparam int unsigned FRAC_LSB       = 3;
  localparam int unsigned FRAC_W         = 11;
  localparam int unsigned VCO_LDO_BIT    = 18;
  localparam int unsigned PLL_LDO_BIT    = 19;
  localparam int unsigned DEMOD_BIAS_BIT = 7;
  localparam int unsigned MON_SEL_BIT    = 3;

  // Integer divide word keeps only bits 10:0; the rest must be zero
  localparam logic [23:0] INT_DIV_MASK   = 24'h0007FF;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [23:0] INT_DIV_RST    = 24'h0001C0;
  localparam logic [23:0] MOD_DIV_RST    = 24'h003001;
  localparam logic [23:0] FRAC_DIV_RST   = 24'h001802;
  localparam logic [7:0]  ALL_WRITTEN    = 8'hFF;
  localparam logic [7:0]  TUNE_REGS      = 8'h07;

  // Monitor source
  typedef enum logic [0:0] {
    SSRC_MON_LOCK = 1'b0,
    SSRC_MON_TEMP = 1'b1
  } ssrc_mon_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][WORD_W-1:0] regs;
    logic                            le_prev;
    logic                            cal_start;
    logic                            mon;
    logic                            frac_en;
    logic [NUM_REGS-1:0]             written;
    logic                            order_err;
    logic [SEL_W-1:0]                last_sel;
  } ssrc_state_t;

endpackage

//--- ssrc_register_control.sv
`timescale 1ns/1ps
// What this block does
// - Seven-plus control words are written only through the three-wire serial port.
// - Writing the integer, modulus or fractional register starts synthesizer calibration.
// - Register 6 bit 18 low powers down the oscillator regulator.
// - Register 6 bit 19 low powers down the reference, detector and pump regulator.
// - Register 5 bit 7 low shuts down the demodulator bias cell.
// - One monitor pin shows either lock detect or a temperature indication.
// - A word is 24 bits: select in 2:0, ratio in 9:3, mode in 10, zeros above for register 0.
// - The divide mode bit chooses fractional or integer-only feedback division.
module ssrc_register_control (
  // System clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // Serial port, clocked by its own serial clock
  input  wire logic                            spi_clk,
  input  wire logic                            spi_data,
  input  wire logic                            spi_le,
  // Monitor sources
  input  wire logic                            lock_detect_in,
  input  wire logic                            temp_indicator_in,
  // Synthesizer controls
  output      logic [ssrc_pkg::INT_RATIO_W-1:0] int_ratio,
  output      logic                            divide_mode_select,
  output      logic                            frac_mode_en,
  output      logic [ssrc_pkg::MOD_W-1:0]       modulus,
  output      logic [ssrc_pkg::FRAC_W-1:0]      fraction,
  output      logic                            cal_start,
  // Power controls
  output      logic                            vco_ldo_en,
  output      logic                            pll_ldo_en,
  output      logic                            demod_bias_en,
  // Monitor and status
  output      logic                            monitor_output_pin,
  output      logic [ssrc_pkg::NUM_REGS-1:0]    regs_written,
  output      logic                            setup_order_err
);
  import ssrc_pkg::*;

  // ****************************************
  // Serial side
  // ****************************************
  logic [WORD_W-1:0] link_word;
  logic [2:0]        sync_lvl;
  logic              le_s;
  logic              lock_s;
  logic              temp_s;

  ssrc_shift u_shift (
    .spi_clk      (spi_clk),
    .spi_data     (spi_data),
    .spi_le       (spi_le),
    .shifted_word (link_word)
  );

  // Latch and monitor levels cross into the system clock
  ssrc_sync #(
    .W (3)
  ) u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .lvl_async ({spi_le, lock_detect_in, temp_indicator_in}),
    .lvl_sync  (sync_lvl)
  );

  assign le_s   = sync_lvl[2];
  assign lock_s = sync_lvl[1];
  assign temp_s = sync_lvl[0];

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_tune_sel(input logic [SEL_W-1:0] sel);
    is_tune_sel = (sel == SEL_INT_DIV) || (sel == SEL_MOD_DIV) || (sel == SEL_FRAC_DIV);
  endfunction

  function automatic logic [WORD_W-1:0] clean_word(input logic [WORD_W-1:0] w);
    if (w[SEL_W-1:0] == SEL_INT_DIV) begin
      clean_word = w & INT_DIV_MASK;
    end else begin
      clean_word = w;
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  ssrc_state_t       st_q;
  ssrc_state_t       st_d;
  logic              le_rise;
  logic [SEL_W-1:0]  wr_sel;

  // The word is stable while the latch is high, because the serial clock
  // only shifts with the latch low; so it is safe to take after the synchroniser
  assign le_rise = le_s & ~st_q.le_prev;
  assign wr_sel  = link_word[SEL_W-1:0];

  always_comb begin
    st_d           = st_q;
    st_d.le_prev   = le_s;
    st_d.cal_start = 1'b0;
    if (le_rise) begin
      st_d.regs[wr_sel] = clean_word(link_word);
      st_d.written[wr_sel] = 1'b1;
      st_d.last_sel = wr_sel;
      if (is_tune_sel(wr_sel)) begin
        st_d.cal_start = 1'b1;
        // Flag a tuning write made before the rest were set up
        if ((st_q.written | TUNE_REGS) != ALL_WRITTEN) begin
          st_d.order_err = 1'b1;
        end
      end
    end
    st_d.frac_en = ~st_q.regs[SEL_INT_DIV][DIV_MODE_BIT];
    if (st_q.regs[SEL_MONITOR][MON_SEL_BIT] == SSRC_MON_TEMP) begin
      st_d.mon = temp_s;
    end else begin
      st_d.mon = lock_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q                    <= '0;
      st_q.regs[SEL_INT_DIV]  <= INT_DIV_RST;
      st_q.regs[SEL_MOD_DIV]  <= MOD_DIV_RST;
      st_q.regs[SEL_FRAC_DIV] <= FRAC_DIV_RST;
      st_q.frac_en            <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs, all from state flops
  // ****************************************
  assign int_ratio          = st_q.regs[SEL_INT_DIV][INT_RATIO_LSB +: INT_RATIO_W];
  assign divide_mode_select = st_q.regs[SEL_INT_DIV][DIV_MODE_BIT];
  assign frac_mode_en       = st_q.frac_en;
  assign modulus            = st_q.regs[SEL_MOD_DIV][MOD_LSB +: MOD_W];
  assign fraction           = st_q.regs[SEL_FRAC_DIV][FRAC_LSB +: FRAC_W];
  assign cal_start          = st_q.cal_start;
  assign vco_ldo_en         = st_q.regs[SEL_LDO][VCO_LDO_BIT];
  assign pll_ldo_en         = st_q.regs[SEL_LDO][PLL_LDO_BIT];
  assign demod_bias_en      = st_q.regs[SEL_BIAS][DEMOD_BIAS_BIT];
  assign monitor_output_pin = st_q.mon;
  assign regs_written       = st_q.written;
  assign setup_order_err    = st_q.order_err;

  // ****************************************
  // Checks
  // ****************************************
  AST_CAL_ON_TUNE: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && is_tune_sel(wr_sel) |=> cal_start ##1 !cal_start)
    else $error("Calibration did not start for a tuning write");

  AST_NO_CAL_OTHER: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && !is_tune_sel(wr_sel) |=> !cal_start)
    else $error("Calibration started for a non-tuning write");

  AST_VCO_LDO: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel == SEL_LDO |=> vco_ldo_en == $past(link_word[VCO_LDO_BIT]))
    else $error("Oscillator regulator enable does not follow bit 18");

  AST_PLL_LDO: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel == SEL_LDO |=> pll_ldo_en == $past(link_word[PLL_LDO_BIT]))
    else $error("Reference regulator enable does not follow bit 19");

  AST_BIAS: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel == SEL_BIAS |=> demod_bias_en == $past(link_word[DEMOD_BIAS_BIT]))
    else $error("Demodulator bias enable does not follow bit 7");

  AST_MONITOR: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(st_q.regs[SEL_MONITOR][MON_SEL_BIT]) |=>
      monitor_output_pin == $past(st_q.regs[SEL_MONITOR][MON_SEL_BIT] ? temp_s : lock_s))
    else $error("Monitor pin shows the wrong source");

  AST_INT_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel == SEL_INT_DIV |=>
      int_ratio == $past(link_word[9:3]) && divide_mode_select == $past(link_word[10]))
    else $error("Integer divide fields not taken from the word");

  AST_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 frac_mode_en == !$past(divide_mode_select))
    else $error("Fractional enable disagrees with divide mode");

  AST_ONLY_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel != SEL_MOD_DIV |=> $stable(modulus))
    else $error("Modulus changed on a write to another register");

  AST_SINGLE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    !le_rise |=> $stable(st_q.regs))
    else $error("Register changed without a serial latch");

  // ****************************************
  // Field and target checks
  // ****************************************
  AST_MOD_FIELD: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel == SEL_MOD_DIV |=> modulus == $past(link_word[MOD_LSB +: MOD_W]))
    else $error("Modulus not taken from the word");

  AST_FRAC_FIELD: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel == SEL_FRAC_DIV |=> fraction == $past(link_word[FRAC_LSB +: FRAC_W]))
    else $error("Fraction not taken from the word");

  AST_FRAC_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel != SEL_FRAC_DIV |=> $stable(fraction))
    else $error("Fraction changed on a write to another register");

  AST_INT_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel != SEL_INT_DIV |=> $stable(int_ratio) && $stable(divide_mode_select))
    else $error("Integer divide changed on a write to another register");

  AST_LDO_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel != SEL_LDO |=> $stable(vco_ldo_en) && $stable(pll_ldo_en))
    else $error("Regulator enable changed on a write to another register");

  AST_BIAS_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel != SEL_BIAS |=> $stable(demod_bias_en))
    else $error("Bias enable changed on a write to another register");

  AST_MON_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel != SEL_MONITOR |=> $stable(st_q.regs[SEL_MONITOR]))
    else $error("Monitor select changed on a write to another register");

  AST_LAST_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise |=> st_q.last_sel == $past(wr_sel) &&
      st_q.regs[st_q.last_sel] == $past(clean_word(link_word)))
    else $error("Addressed register does not hold the latched word");

  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.regs[SEL_INT_DIV] & ~INT_DIV_MASK) == '0)
    else $error("Integer divide word holds bits above the mode bit");

  // Every register but the addressed one must keep its word
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_keep
    AST_KEEP_OTHERS: assert property (@(posedge clk) disable iff (!rst_n)
      le_rise && wr_sel != SEL_W'(g) |=> $stable(st_q.regs[g]))
      else $error("A register changed on a write to another one");
  end

  // ****************************************
  // Calibration and status checks
  // ****************************************
  AST_CAL_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    cal_start |=> !cal_start)
    else $error("Calibration start longer than one cycle");

  AST_CAL_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
    cal_start |-> $past(le_rise && is_tune_sel(wr_sel)))
    else $error("Calibration started without a tuning write");

  AST_WRITTEN_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !le_rise |=> $stable(regs_written))
    else $error("Written flags changed without a latch");

  AST_WRITTEN_SET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise |=> st_q.written[st_q.last_sel])
    else $error("Written flag not set for the addressed register");

  AST_ORDER_SET: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && is_tune_sel(wr_sel) && ((regs_written | TUNE_REGS) != ALL_WRITTEN) |=> setup_order_err)
    else $error("Early tuning write not flagged");

  AST_ORDER_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    setup_order_err |=> setup_order_err)
    else $error("Order error flag cleared outside reset");

  AST_ORDER_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(setup_order_err) |-> $past(le_rise && is_tune_sel(wr_sel)))
    else $error("Order error raised without a tuning write");

  AST_ORDER_CLEAN: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && regs_written == ALL_WRITTEN |=> $stable(setup_order_err))
    else $error("Order error changed after full setup");

  AST_MODE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel != SEL_INT_DIV |=> ##1 $stable(frac_mode_en))
    else $error("Fractional enable moved on a write to another register");

  // ****************************************
  // Reset checks
  // ****************************************
  AST_RESET_TUNE: assert property (@(posedge clk)
    !rst_n |=> int_ratio == INT_DIV_RST[INT_RATIO_LSB +: INT_RATIO_W] && !divide_mode_select &&
      modulus == MOD_DIV_RST[MOD_LSB +: MOD_W] && fraction == FRAC_DIV_RST[FRAC_LSB +: FRAC_W])
    else $error("Tuning registers not at their reset values");

  AST_RESET_STATUS: assert property (@(posedge clk)
    !rst_n |=> frac_mode_en && !cal_start && regs_written == '0 && !setup_order_err)
    else $error("Status not cleared by reset");

  AST_RESET_POWER: assert property (@(posedge clk)
    !rst_n |=> !vco_ldo_en && !pll_ldo_en && !demod_bias_en)
    else $error("Power enables not off after reset");

  COV_TUNE: cover property (@(posedge clk) disable iff (!rst_n)
    le_rise && wr_sel == SEL_INT_DIV ##1 cal_start);
  COV_SETUP_DONE: cover property (@(posedge clk) disable iff (!rst_n)
    regs_written == ALL_WRITTEN && !setup_order_err);
  COV_ORDER_ERR: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(setup_order_err));
  COV_TEMP_MON: cover property (@(posedge clk) disable iff (!rst_n)
    st_q.regs[SEL_MONITOR][MON_SEL_BIT] && monitor_output_pin);
  COV_RETUNE: cover property (@(posedge clk) disable iff (!rst_n)
    regs_written == ALL_WRITTEN && cal_start);

endmodule // ssrc_register_control

//--- ssrc_shift.sv
`timescale 1ns/1ps
module ssrc_shift (
  // Link clock
  input  wire logic                       spi_clk,
  // Serial pins
  input  wire logic                       spi_data,
  input  wire logic                       spi_le,
  // Assembled word
  output      logic [ssrc_pkg::WORD_W-1:0] shifted_word
);
  import ssrc_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] shreg;
  } ssrc_shift_state_t;

  ssrc_shift_state_t st_q;
  ssrc_shift_state_t st_d;

  // Shift MSB first while the latch is low; the word holds still while it is high
  // No reset: the serial clock may stand still, and the word is only used after a latch
  always_comb begin
    st_d = st_q;
    if (!spi_le) begin
      st_d.shreg = {st_q.shreg[WORD_W-2:0], spi_data};
    end
  end

  always_ff @(posedge spi_clk) begin
    st_q <= st_d;
  end

  assign shifted_word = st_q.shreg;

endmodule // ssrc_shift

//--- ssrc_sync.sv
`timescale 1ns/1ps
module ssrc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels from another domain
  input  wire logic [W-1:0] lvl_async,
  output      logic [W-1:0] lvl_sync
);
  import ssrc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssrc_sync_state_t;

  ssrc_sync_state_t st_q;
  ssrc_sync_state_t st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d    = st_q;
    st_d.s1 = lvl_async;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lvl_sync = st_q.s2;

endmodule // ssrc_sync

//--- test_synth_spi_register_control.sv
`timescale 1ns/1ps
module test_synth_spi_register_control;
  typedef struct packed {
    logic [23:0] w;
    logic [33:0] o;
    logic [1:0]  cal;
  } ssrc_row_t;

  logic clk, rst_n, lock_in, temp_in, spi_clk, spi_data, spi_le;
  logic [6:0]  int_ratio;
  logic        dm, frac_en, cal_start, vco, pll, bias, mon, order_err;
  logic [10:0] modulus, fraction;
  logic [7:0]  written;
  logic [1:0]  cal_cnt;
  int          err_count, total_checks;
  ssrc_row_t   rows [8];

  ssrc_host_model ssrc_host_model_inst (.spi_clk(spi_clk), .spi_data(spi_data), .spi_le(spi_le));
  ssrc_register_control ssrc_register_control_inst (
    .clk(clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_data(spi_data), .spi_le(spi_le),
    .lock_detect_in(lock_in), .temp_indicator_in(temp_in), .int_ratio(int_ratio),
    .divide_mode_select(dm), .frac_mode_en(frac_en), .modulus(modulus), .fraction(fraction),
    .cal_start(cal_start), .vco_ldo_en(vco), .pll_ldo_en(pll), .demod_bias_en(bias),
    .monitor_output_pin(mon), .regs_written(written), .setup_order_err(order_err));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cal_start === 1'b1) cal_cnt <= cal_cnt + 2'h1;
  end

  function automatic logic [33:0] outs();
    return {int_ratio, dm, modulus, fraction, vco, pll, bias, mon};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Three-cycle reset, then let the synchronisers settle
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [23:0] w);
    @(posedge clk);
    #1 cal_cnt = 2'h0;
    ssrc_host_model_inst.send_word(w);
  endtask

  initial begin
    #50000;
    err_count++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    lock_in = 1'b1;
    temp_in = 1'b0;
    cal_cnt = 2'h0;
    err_count = 0;
    total_checks = 0;
    // Initial setup from register 7 down to 0, tuning words last
    rows[0] = '{24'h00000F, {7'h38, 1'h0, 11'h600, 11'h300, 4'b0000}, 2'h0};
    rows[1] = '{24'h0C0006, {7'h38, 1'h0, 11'h600, 11'h300, 4'b1100}, 2'h0};
    rows[2] = '{24'h000085, {7'h38, 1'h0, 11'h600, 11'h300, 4'b1110}, 2'h0};
    rows[3] = '{24'h000004, {7'h38, 1'h0, 11'h600, 11'h300, 4'b1110}, 2'h0};
    rows[4] = '{24'h000003, {7'h38, 1'h0, 11'h600, 11'h300, 4'b1110}, 2'h0};
    rows[5] = '{24'h00002A, {7'h38, 1'h0, 11'h600, 11'h005, 4'b1110}, 2'h1};
    rows[6] = '{24'h003FF9, {7'h38, 1'h0, 11'h7FF, 11'h005, 4'b1110}, 2'h1};
    // Stray upper bits in the integer word must not disturb anything
    rows[7] = '{24'hFFF7D8, {7'h7B, 1'h1, 11'h7FF, 11'h005, 4'b1110}, 2'h1};
    do_reset();
    check(outs(), {7'h38, 1'h0, 11'h600, 11'h300, 4'b0001}, "reset outputs");
    check({25'h0, written, frac_en}, {25'h0, 8'h00, 1'b1}, "reset status");
    foreach (rows[i]) begin
      send(rows[i].w);
      check(outs(), rows[i].o, "row outputs");
      check({32'h0, cal_cnt}, {32'h0, rows[i].cal}, "calibration pulses");
    end
    check({33'h0, frac_en}, 34'h0, "integer mode");
    check({25'h0, written, order_err}, {25'h0, 8'hFF, 1'b0}, "ordered setup");
    // Retune by the integer word alone, fractional mode
    send(24'h0000C0);
    check({26'h0, int_ratio, frac_en}, {26'h0, 7'h18, 1'b1}, "retune fractional");
    check({32'h0, cal_cnt}, 34'h1, "retune calibration");
    // Each regulator bit alone, then monitor back to lock detect
    send(24'h080006);
    check({30'h0, vco, pll, bias, mon}, {30'h0, 4'b0110}, "oscillator regulator off");
    send(24'h040006);
    check({30'h0, vco, pll, bias, mon}, {30'h0, 4'b1010}, "pump regulator off");
    send(24'h000005);
    check({30'h0, vco, pll, bias, mon}, {30'h0, 4'b1000}, "bias off");
    send(24'h000007);
    check({33'h0, mon}, 34'h1, "monitor lock detect");
    @(posedge clk);
    #1 lock_in = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check({33'h0, mon}, 34'h0, "monitor follows lock");
    // Mid-run reset, then a tuning word before any other register
    @(posedge clk);
    #1 do_reset();
    check(outs(), {7'h38, 1'h0, 11'h600, 11'h300, 4'b0000}, "second reset");
    send(24'h000140);
    check({25'h0, written, order_err}, {25'h0, 8'h01, 1'b1}, "out of order");
    check({27'h0, int_ratio}, {27'h0, 7'h28}, "ratio stored");
    finish_test();
  end
endmodule // test_synth_spi_register_control
